//--- design/tsac_defs.vh
// constants for the temperature sensor alert and mode control block
// assumes a 20 MHz system clock and plain Verilog-2005 tools
`ifndef TSAC_DEFS_VH
`define TSAC_DEFS_VH

`define TSAC_CLK_HZ        20000000
`define TSAC_CFG_RST       16'h00ff
`define TSAC_LOW_RST       12'h4b0
`define TSAC_HIGH_RST      12'h500
`define TSAC_BIT_TRIG      15
`define TSAC_BIT_RATE_HI   14
`define TSAC_BIT_RATE_LO   13
`define TSAC_BIT_FQ_HI     12
`define TSAC_BIT_FQ_LO     11
`define TSAC_BIT_POL       10
`define TSAC_BIT_BEH       9
`define TSAC_BIT_SD        8
`define TSAC_ARA_CODE      8'h19
`define TSAC_GC_ADDR       7'h00
`define TSAC_GC_RESET      8'h06
`define TSAC_HS_PREFIX     5'h01
// conversion time 5.5 ms = 55 tenths of ms
`define TSAC_CONV_TENTH_MS 55
// base period 27.5 ms in tenths of ms
`define TSAC_BASE_TENTH_MS 275
`define TSAC_TIMEOUT_MS    25

`endif

//--- design/tsac_top.v
// alert, mode and conversion sequencing of a two-wire temperature sensor
// assumes scl/sda pins arrive asynchronously; the analog converter sits outside
`timescale 1ns/1ps
`include "tsac_defs.vh"

module tsac_top #(
  parameter CONV_CYC    = (`TSAC_CONV_TENTH_MS * (`TSAC_CLK_HZ / 10000)),
  parameter BASE_CYC    = (`TSAC_BASE_TENTH_MS * (`TSAC_CLK_HZ / 10000)),
  parameter TIMEOUT_CYC = (`TSAC_TIMEOUT_MS * (`TSAC_CLK_HZ / 1000))
) (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire [6:0]  dev_addr,
  input  wire        cfg_wr,
  input  wire [15:0] cfg_wdata,
  input  wire        reg_rd,
  input  wire [11:0] low_limit_wr,
  input  wire [11:0] high_limit_wr,
  input  wire        limit_wr,
  input  wire [11:0] adc_result,
  output reg  [15:0] cfg_rdata,
  output reg  [11:0] temp_result,
  output reg  [11:0] low_limit,
  output reg  [11:0] high_limit,
  output reg         alert_pin,
  output reg         converting,
  output reg         hs_mode,
  output reg         gc_reset_pulse
);

  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK  = 3'd2;
  localparam ST_CMD  = 3'd3;
  localparam ST_TX   = 3'd4;
  localparam ST_SKIP = 3'd5;
  localparam ST_TXAK = 3'd6;

  // =====================================================
  // pin synchronisers and edge detection
  reg [2:0] scl_s;
  reg [2:0] sda_s;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scl_s <= 3'b111;
      sda_s <= 3'b111;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
    end
  end
  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire start_c  = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  wire stop_c   = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  // =====================================================
  // configuration and alert state
  reg [15:0] cfg;
  reg        alert_act;
  reg        watch_low;
  reg        cause_high;
  reg [1:0]  fault_cnt;
  reg        ara_clear;
  reg        trig_pend;
  reg [23:0] conv_cnt;
  reg [24:0] per_cnt;
  reg        conv_done;
  reg        gc_rst;

  function [24:0] period_of;
    input [1:0] rate;
    begin
      period_of = BASE_CYC[24:0] << rate;
    end
  endfunction

  wire sd_bit  = cfg[`TSAC_BIT_SD];
  wire beh_bit = cfg[`TSAC_BIT_BEH];
  wire pol_bit = cfg[`TSAC_BIT_POL];
  wire [1:0] fq = cfg[`TSAC_BIT_FQ_HI:`TSAC_BIT_FQ_LO];
  wire beh_write = cfg_wr;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      conv_cnt   <= 24'h000000;
      per_cnt    <= 25'h0000000;
      converting <= 1'b0;
      conv_done  <= 1'b0;
      trig_pend  <= 1'b0;
    end else if (gc_rst) begin
      conv_cnt   <= 24'h000000;
      per_cnt    <= 25'h0000000;
      converting <= 1'b0;
      conv_done  <= 1'b0;
      trig_pend  <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (cfg_wr && cfg_wdata[`TSAC_BIT_TRIG] && cfg_wdata[`TSAC_BIT_SD])
        trig_pend <= 1'b1;
      if (converting) begin
        if (conv_cnt == CONV_CYC - 1) begin
          converting <= 1'b0;
          conv_done  <= 1'b1;
          conv_cnt   <= 24'h000000;
        end else begin
          conv_cnt <= conv_cnt + 24'h000001;
        end
      end else if (trig_pend && sd_bit) begin
        trig_pend  <= 1'b0;
        converting <= 1'b1;
      end else if (!sd_bit && per_cnt == 25'h0000000) begin
        converting <= 1'b1;
      end
      if (sd_bit)
        per_cnt <= 25'h0000000;
      else if (per_cnt >= period_of(cfg[`TSAC_BIT_RATE_HI:`TSAC_BIT_RATE_LO]) - 1)
        per_cnt <= 25'h0000000;
      else
        per_cnt <= per_cnt + 25'h0000001;
    end
  end

  reg cmp_go;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      temp_result <= 12'h000;
      cmp_go      <= 1'b0;
    end else begin
      cmp_go <= conv_done & ~gc_rst;
      if (gc_rst)
        temp_result <= 12'h000;
      else if (conv_done)
        temp_result <= adc_result;
    end
  end

  wire is_high = $signed(temp_result) >= $signed(high_limit);
  wire is_low  = $signed(temp_result) < $signed(low_limit);
  wire hit     = watch_low ? is_low : is_high;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg        <= `TSAC_CFG_RST;
      low_limit  <= `TSAC_LOW_RST;
      high_limit <= `TSAC_HIGH_RST;
      alert_act  <= 1'b0;
      watch_low  <= 1'b0;
      cause_high <= 1'b0;
      fault_cnt  <= 2'd0;
    end else if (gc_rst) begin
      cfg        <= `TSAC_CFG_RST;
      low_limit  <= `TSAC_LOW_RST;
      high_limit <= `TSAC_HIGH_RST;
      alert_act  <= 1'b0;
      watch_low  <= 1'b0;
      cause_high <= 1'b0;
      fault_cnt  <= 2'd0;
    end else begin
      if (limit_wr) begin
        low_limit  <= low_limit_wr;
        high_limit <= high_limit_wr;
      end
      if (beh_write) begin
        cfg       <= {1'b0, cfg_wdata[14:0]};
        alert_act <= 1'b0;
        watch_low <= 1'b0;
        fault_cnt <= 2'd0;
      end else if (cmp_go) begin
        if (!beh_bit) begin
          if ((alert_act ? is_low : is_high)) begin
            if (fault_cnt == fq) begin
              alert_act  <= ~alert_act;
              cause_high <= ~alert_act;
              fault_cnt  <= 2'd0;
            end else begin
              fault_cnt <= fault_cnt + 2'd1;
            end
          end else begin
            fault_cnt <= 2'd0;
          end
        end else if (!alert_act) begin
          if (hit) begin
            if (fault_cnt == fq) begin
              alert_act  <= 1'b1;
              cause_high <= ~watch_low;
              fault_cnt  <= 2'd0;
            end else begin
              fault_cnt <= fault_cnt + 2'd1;
            end
          end else begin
            fault_cnt <= 2'd0;
          end
        end
      end else if (beh_bit && alert_act && (reg_rd || ara_clear)) begin
        // clear, then watch the other limit
        alert_act <= 1'b0;
        watch_low <= ~watch_low;
      end
    end
  end

  // =====================================================
  // serial side: address match, alert response, general call, hs
  reg [2:0]  st;
  reg [3:0]  bit_cnt;
  reg [7:0]  shreg;
  reg        first_byte;
  reg        is_gc;
  reg        is_ara;
  reg        ack_now;
  reg        lost;
  reg [7:0]  tx_byte;
  reg [22:0] to_cnt;
  reg        in_frame;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st             <= ST_IDLE;
      bit_cnt        <= 4'd0;
      shreg          <= 8'h00;
      first_byte     <= 1'b0;
      is_gc          <= 1'b0;
      is_ara         <= 1'b0;
      ack_now        <= 1'b0;
      lost           <= 1'b0;
      tx_byte        <= 8'h00;
      to_cnt         <= 23'd0;
      in_frame       <= 1'b0;
      sda_out        <= 1'b0;
      sda_oe         <= 1'b0;
      hs_mode        <= 1'b0;
      ara_clear      <= 1'b0;
      gc_rst         <= 1'b0;
      gc_reset_pulse <= 1'b0;
    end else begin
      ara_clear      <= 1'b0;
      gc_rst         <= 1'b0;
      gc_reset_pulse <= 1'b0;
      if (in_frame && !sda_s[2])
        to_cnt <= to_cnt + 23'd1;
      else
        to_cnt <= 23'd0;
      if (stop_c) begin
        st       <= ST_IDLE;
        sda_oe   <= 1'b0;
        in_frame <= 1'b0;
        hs_mode  <= 1'b0;
      end else if (in_frame && to_cnt >= TIMEOUT_CYC - 1) begin
        st       <= ST_IDLE;
        sda_oe   <= 1'b0;
        in_frame <= 1'b0;
      end else if (start_c) begin
        st         <= ST_ADDR;
        bit_cnt    <= 4'd0;
        first_byte <= 1'b1;
        in_frame   <= 1'b1;
        sda_oe     <= 1'b0;
      end else begin
        case (st)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR, ST_CMD: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_s[2]};
              bit_cnt <= bit_cnt + 4'd1;
            end else if (scl_fall && bit_cnt == 4'd8) begin
              bit_cnt <= 4'd0;
              ack_now <= 1'b0;
              if (st == ST_CMD) begin
                if (is_gc && shreg == `TSAC_GC_RESET) begin
                  gc_rst         <= 1'b1;
                  gc_reset_pulse <= 1'b1;
                end
                st      <= ST_ACK;
                sda_oe  <= 1'b1;
                sda_out <= 1'b0;
                is_gc   <= 1'b0;
              end else if (first_byte && shreg[7:3] == `TSAC_HS_PREFIX) begin
                hs_mode <= 1'b1;
                st      <= ST_SKIP;
              end else if (shreg[7:1] == `TSAC_GC_ADDR && !shreg[0]) begin
                is_gc   <= 1'b1;
                st      <= ST_ACK;
                ack_now <= 1'b1;
                sda_oe  <= 1'b1;
                sda_out <= 1'b0;
              end else if (shreg == `TSAC_ARA_CODE && alert_act && beh_bit) begin
                // answer alert response in interrupt mode only
                is_ara  <= 1'b1;
                st      <= ST_ACK;
                sda_oe  <= 1'b1;
                sda_out <= 1'b0;
                tx_byte <= {dev_addr, cause_high ? pol_bit : ~pol_bit};
              end else if (shreg[7:1] == dev_addr) begin
                st      <= ST_ACK;
                sda_oe  <= 1'b1;
                sda_out <= 1'b0;
              end else begin
                st <= ST_SKIP;
              end
              first_byte <= 1'b0;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (is_ara) begin
                st      <= ST_TX;
                lost    <= 1'b0;
                sda_oe  <= ~tx_byte[7];
                sda_out <= 1'b0;
                bit_cnt <= 4'd1;
              end else begin
                sda_oe <= 1'b0;
                st     <= ack_now ? ST_CMD : ST_SKIP;
              end
            end
          end
          ST_TX: begin
            if (scl_rise && sda_oe == 1'b0 && !sda_s[2]) begin
              lost <= 1'b1;
              st   <= ST_SKIP;
            end else if (scl_fall) begin
              if (bit_cnt == 4'd8) begin
                sda_oe <= 1'b0;
                st     <= ST_TXAK;
              end else begin
                sda_oe  <= ~tx_byte[3'd7 - bit_cnt[2:0]];
                bit_cnt <= bit_cnt + 4'd1;
              end
            end
          end
          ST_TXAK: begin
            if (scl_fall) begin
              ara_clear <= ~lost;
              is_ara    <= 1'b0;
              st        <= ST_SKIP;
            end
          end
          ST_SKIP: begin
            sda_oe <= 1'b0;
            is_ara <= 1'b0;
          end
          default: st <= ST_IDLE;
        endcase
      end
    end
  end

  // =====================================================
  // registered outputs
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      alert_pin <= 1'b1;
      cfg_rdata <= `TSAC_CFG_RST;
    end else begin
      alert_pin <= alert_act ? pol_bit : ~pol_bit;
      cfg_rdata <= {1'b0, cfg[14:0]};
    end
  end

endmodule // tsac_top

//--- testbench/tb_top.sv
// self-checking bench for the alert and mode control block
// assumes tsac_host_model on the bus and shortened counts
`timescale 1ns/1ps
module tb_top;
  localparam int CONV = 20;
  localparam int BASE = 100;
  localparam int TOUT = 200;
  logic        clk_sys   = 1'b0;
  logic        nrst      = 1'b0;
  logic        cfg_wr    = 1'b0;
  logic [15:0] cfg_wdata = 16'h0000;
  logic        reg_rd    = 1'b0;
  logic        limit_wr  = 1'b0;
  logic [11:0] adc       = 12'h000;
  logic [6:0]  dev_addr  = 7'h48;
  logic        ack;
  logic [7:0]  rb;
  int          hi, per, k, mismatches, n_checks;
  wire         scl, sda_drv, sda_out, sda_oe, alert, conv, hs, gc;
  wire  [15:0] cfg_rdata;
  wire  [11:0] temp, low_limit, high_limit;
  wire         sda = sda_drv & (sda_oe ? sda_out : 1'b1);
  always #25 clk_sys = ~clk_sys;
  tsac_host_model host_u (.scl(scl), .sda_drv(sda_drv), .sda_line(sda));
  tsac_top #(.CONV_CYC(CONV), .BASE_CYC(BASE), .TIMEOUT_CYC(TOUT)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .dev_addr(dev_addr), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .reg_rd(reg_rd), .low_limit_wr(12'h100), .high_limit_wr(12'h200), .limit_wr(limit_wr),
    .adc_result(adc), .cfg_rdata(cfg_rdata), .temp_result(temp), .low_limit(low_limit),
    .high_limit(high_limit), .alert_pin(alert), .converting(conv), .hs_mode(hs),
    .gc_reset_pulse(gc));
  // ==========================================
  // tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic pulse_cfg(input logic [15:0] w);
    cfg_wdata = w;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(3);
  endtask
  // conversion pulse width and period, from one rise
  task automatic meas();
    k = 0;
    hi = 0;
    per = 0;
    while (conv !== 1'b1 && k < 3000) begin cyc(1); k++; end
    while (conv === 1'b1 && k < 3000) begin cyc(1); k++; hi++; per++; end
    while (conv !== 1'b1 && k < 3000) begin cyc(1); k++; per++; end
    if (k >= 3000) begin mismatches++; wrap_up(); end
  endtask
  task automatic conv_end();
    meas();
    cyc(4);
  endtask
  // single conversion in shutdown: no next rise follows
  task automatic shot();
    k = 0;
    while (conv !== 1'b1 && k < 3000) begin cyc(1); k++; end
    while (conv === 1'b1 && k < 3000) begin cyc(1); k++; end
    if (k >= 3000) begin mismatches++; wrap_up(); end
    cyc(4);
  endtask
  task automatic alert_is(input logic e);
    chk("alert", {15'h0, e}, {15'h0, alert});
  endtask
  task automatic ara(input logic e, input logic lsb);
    host_u.start();
    host_u.wbyte(8'h19, ack);
    chk("ara ack", {15'h0, e}, {15'h0, ack});
    if (ack === 1'b1) begin
      host_u.rbyte(rb);
      chk("ara addr", {8'h0, dev_addr, lsb}, {8'h0, rb});
    end
    host_u.stop();
    cyc(4);
  endtask
  // ==========================================
  // sequence
  initial begin
    cyc(16);
    nrst = 1'b1;
    cyc(2);
    chk("cfg reset", 16'h00ff, cfg_rdata);
    alert_is(1'b1);
    limit_wr = 1'b1;
    cyc(1);
    limit_wr = 1'b0;
    for (int r = 0; r < 4; r++) begin
      pulse_cfg({1'b0, r[1:0], 13'h0});
      meas();
      meas();
      chk("conv width", CONV, hi);
      chk("conv period", BASE << r, per);
    end
    adc = 12'h250;
    pulse_cfg(16'h0800);
    conv_end();
    alert_is(1'b1);
    conv_end();
    alert_is(1'b0);
    ara(1'b0, 1'b0);
    adc = 12'h050;
    conv_end();
    alert_is(1'b0);
    conv_end();
    alert_is(1'b1);
    pulse_cfg(16'h0c00);
    alert_is(1'b0);
    adc = 12'h250;
    conv_end();
    conv_end();
    alert_is(1'b1);
    pulse_cfg(16'h0200);
    conv_end();
    alert_is(1'b0);
    ara(1'b1, 1'b0);
    alert_is(1'b1);
    adc = 12'h050;
    conv_end();
    alert_is(1'b0);
    ara(1'b1, 1'b1);
    adc = 12'h250;
    conv_end();
    alert_is(1'b0);
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cyc(4);
    alert_is(1'b1);
    pulse_cfg(16'h0100);
    cyc(BASE);
    k = 0;
    repeat (300) begin cyc(1); if (conv !== 1'b0) k++; end
    chk("sd conv", 16'h0, k);
    pulse_cfg(16'h8100);
    shot();
    chk("cfg read", 16'h0100, cfg_rdata);
    k = 0;
    repeat (300) begin cyc(1); if (conv !== 1'b0) k++; end
    chk("one shot", 16'h0, k);
    host_u.start();
    host_u.wbyte(8'h08, ack);
    chk("hs ack", 16'h0, {15'h0, ack});
    host_u.start();
    chk("hs kept", 16'h1, {15'h0, hs});
    host_u.stop();
    cyc(4);
    chk("hs stop", 16'h0, {15'h0, hs});
    host_u.start();
    cyc(TOUT + 50);
    host_u.start();
    host_u.wbyte(8'h00, ack);
    chk("gc ack", 16'h1, {15'h0, ack});
    host_u.wbyte(8'h06, ack);
    chk("cmd ack", 16'h1, {15'h0, ack});
    host_u.stop();
    cyc(2);
    chk("gc cfg", 16'h00ff, cfg_rdata);
    chk("gc low", 16'h04b0, {4'h0, low_limit});
    wrap_up();
  end
endmodule // tb_top

//--- testbench/tsac_host_model.sv
// two-wire bus host model for the sensor's serial pins
// assumes a pulled-up data line resolved by tb_top
`timescale 1ns/1ps
module tsac_host_model (
  output logic scl,
  output logic sda_drv,
  input  wire  sda_line
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic bitx(input logic b, output logic r);
    sda_drv = b;
    #100 scl = 1'b1;
    #100 r = sda_line;
    #100 scl = 1'b0;
    #100;
  endtask
  task automatic start();
    sda_drv = 1'b1;
    #100 scl = 1'b1;
    #100 sda_drv = 1'b0;
    #100 scl = 1'b0;
    #100;
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    #100 scl = 1'b1;
    #100 sda_drv = 1'b1;
    #200;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(1'b1, r);
  endtask
endmodule // tsac_host_model

//--- testbench/tsac_top_assertions.sv
// port checker for the alert and mode control block
// assumes a bind into tsac_top with its shortened parameters
`timescale 1ns/1ps
`include "tsac_defs.vh"
module tsac_chk #(
  parameter TIMEOUT_CYC = 200
) (
  input wire        clk_sys,
  input wire        nrst,
  input wire        scl_in,
  input wire        cfg_wr,
  input wire [15:0] cfg_rdata,
  input wire [11:0] low_limit,
  input wire [11:0] high_limit,
  input wire        sda_oe,
  input wire        alert_pin,
  input wire        converting,
  input wire        hs_mode,
  input wire        gc_reset_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  int unsigned low_cnt;
  // cycles the data line has been held by us
  always @(posedge clk_sys or negedge nrst)
    if (!nrst) low_cnt <= 0;
    else low_cnt <= sda_oe ? low_cnt + 1 : 0;
  // ==========================================
  // properties
  property p_os_zero; cfg_rdata[15] == 1'b0; endproperty
  a_os_zero: assert property (p_os_zero) else $error("trigger bit reads set");
  property p_cfg_clr; cfg_wr |-> ##[1:3] (alert_pin != cfg_rdata[10]); endproperty
  a_cfg_clr: assert property (p_cfg_clr) else $error("alert kept after cfg write");
  property p_hs_hold; (hs_mode && !scl_in) [*4] |=> hs_mode; endproperty
  a_hs_hold: assert property (p_hs_hold) else $error("fast mode before stop");
  property p_sd_idle;
    (!cfg_wr && !gc_reset_pulse) [*4] ##0 (cfg_rdata[8] && !converting) |=> !converting;
  endproperty
  a_sd_idle: assert property (p_sd_idle) else $error("conversion in shutdown");
  property p_gc_regs;
    gc_reset_pulse |-> ##[1:2] (cfg_rdata == `TSAC_CFG_RST && low_limit == `TSAC_LOW_RST
                                && high_limit == `TSAC_HIGH_RST);
  endproperty
  a_gc_regs: assert property (p_gc_regs) else $error("registers not at power-up");
  property p_hs_noack; $rose(hs_mode) |-> !sda_oe [*8]; endproperty
  a_hs_noack: assert property (p_hs_noack) else $error("high-speed code acked");
  property p_one_shot; $fell(converting) && cfg_rdata[8] |=> !converting [*8]; endproperty
  a_one_shot: assert property (p_one_shot) else $error("second conversion in shutdown");
  property p_timeout; low_cnt <= TIMEOUT_CYC + 16; endproperty
  a_timeout: assert property (p_timeout) else $error("data line held past timeout");
  c_hs: cover property ($rose(hs_mode));
  c_gc: cover property (gc_reset_pulse);
  c_alert: cover property ($fell(alert_pin));
endmodule // tsac_chk

bind tsac_top tsac_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (
  .clk_sys(clk_sys), .nrst(nrst), .scl_in(scl_in), .cfg_wr(cfg_wr), .cfg_rdata(cfg_rdata),
  .low_limit(low_limit), .high_limit(high_limit), .sda_oe(sda_oe), .alert_pin(alert_pin),
  .converting(converting), .hs_mode(hs_mode), .gc_reset_pulse(gc_reset_pulse));
